/* hdl/sssf_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sssf_cfg.svh"
module sssf_top
	import sssf_pkg::*;
#(
	parameter int COUNT_W = 10,
	parameter logic [9:0] DEPTH = 10'h200,
	parameter int ADDR_W = 9
) (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// AXI4-Lite write address
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// sample path events
	input wire logic newSample,
	input wire logic samplePush,
	input wire logic fifoPop,
	// upper status bits from neighbouring blocks
	input wire logic [3:0] statusUpper,
	// data register lookup in the sample path
	output logic dataRdStrobe,
	output logic [6:0] dataRdIndex,
	input wire logic [7:0] dataRdValue,
	// FIFO storage strobes
	output logic fifoWriteEn,
	output logic fifoDropOldest,
	// interrupt
	output logic irq
);
	// write channel holding registers
	logic awHeld_r;
	logic wHeld_r;
	logic [6:0] awIdx_r;
	logic [31:0] wData_r;
	logic [3:0] wStrb_r;
	logic doWrite; // both halves present and response slot free
	// read channel
	sssf_rd_state_e rdState_r;
	logic [6:0] rdIdx_r;
	logic rdIsData_r;
	logic arTaken;
	logic [6:0] arIdx;
	logic arIsData;
	logic arClears;
	logic rdClears_r;
	logic readEnd;
	// software registers
	logic [COUNT_W-1:0] thr_r;
	logic [1:0] pol_r;
	logic [3:0] irqStat_r;
	logic [3:0] irqEn_r;
	logic [3:0] irqClr; // write-one-to-clear pulses
	// block state
	logic [COUNT_W-1:0] count;
	logic overflow;
	logic levelReached;
	logic nonEmpty;
	logic dataReady;
	logic [3:0] flags; // low status nibble
	logic [3:0] flagsPrev_r;
	logic [3:0] events;
	logic [3:0] irqStat_nxt;
	logic [31:0] rdMux;
	logic rdOk;

	////////////////////////////////////////////////////////////////
	// occupancy and overflow tracking
	sssf_fill_counter #(
		.COUNT_W(COUNT_W),
		.DEPTH(DEPTH)
	) u_fill (
		.clk(clk),
		.resetn(resetn),
		.policy(sssf_policy_e'(pol_r)),
		.threshold(thr_r),
		.samplePush(samplePush),
		.fifoPop(fifoPop),
		.count_r(count),
		.overflow_r(overflow),
		.levelReached_r(levelReached),
		.nonEmpty_r(nonEmpty),
		.writeEn_r(fifoWriteEn),
		.dropOldest_r(fifoDropOldest)
	);

	////////////////////////////////////////////////////////////////
	// data ready flag with read-window handling
	sssf_data_ready u_drdy (
		.clk(clk),
		.resetn(resetn),
		.newSample(newSample),
		.readStart(arTaken && arIsData),
		.readEnd(readEnd),
		.readClears(rdClears_r),
		.dataReady_r(dataReady)
	);

	////////////////////////////////////////////////////////////////
	// read address decode
	always_comb begin
		arTaken = s_axi_arvalid && s_axi_arready;
		arIdx = s_axi_araddr[8:2];
		arIsData = ((arIdx >= `SSSF_IDX_DATA8_FIRST) && (arIdx <= `SSSF_IDX_DATA8_LAST)) ||
			((arIdx >= `SSSF_IDX_DATA14_FIRST) && (arIdx <= `SSSF_IDX_DATA14_LAST));
		// upper axis bytes leave the flag for the following lower byte read
		arClears = !((arIdx == `SSSF_IDX_XHI) || (arIdx == `SSSF_IDX_YHI) ||
			(arIdx == `SSSF_IDX_ZHI));
		readEnd = s_axi_rvalid && s_axi_rready && rdIsData_r;
	end

	////////////////////////////////////////////////////////////////
	// read channel: accept, fetch, answer
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdState_r <= RD_IDLE;
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `SSSF_RESP_OKAY;
			rdIdx_r <= 7'h00;
			rdIsData_r <= 1'b0;
			rdClears_r <= 1'b0;
		end else begin
			case (rdState_r)
				RD_IDLE: begin
					if (arTaken) begin
						rdState_r <= RD_FETCH;
						s_axi_arready <= 1'b0;
						rdIdx_r <= arIdx;
						rdIsData_r <= arIsData;
						rdClears_r <= arClears;
					end
				end
				RD_FETCH: begin
					// sample path answers during the fetch cycle
					rdState_r <= RD_RESP;
					s_axi_rvalid <= 1'b1;
					s_axi_rdata <= rdMux;
					s_axi_rresp <= rdOk ? `SSSF_RESP_OKAY : `SSSF_RESP_SLVERR;
				end
				RD_RESP: begin
					if (s_axi_rready) begin
						rdState_r <= RD_IDLE;
						s_axi_rvalid <= 1'b0;
						s_axi_arready <= 1'b1;
					end
				end
				default: begin
					rdState_r <= RD_IDLE;
					s_axi_arready <= 1'b1;
					s_axi_rvalid <= 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// lookup strobe toward the sample path
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			dataRdStrobe <= 1'b0;
			dataRdIndex <= 7'h00;
		end else begin
			dataRdStrobe <= arTaken && arIsData;
			if (arTaken) begin
				dataRdIndex <= arIdx;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// read data multiplexer; unmapped words read zero with an error
	always_comb begin
		flags = 4'h0;
		flags[`SSSF_BIT_OVF] = overflow;
		flags[`SSSF_BIT_LEVEL] = levelReached;
		flags[`SSSF_BIT_FREADY] = nonEmpty;
		flags[`SSSF_BIT_DRDY] = dataReady;
		rdMux = 32'h0000_0000;
		rdOk = 1'b1;
		if (rdIsData_r) begin
			rdMux[7:0] = dataRdValue;
		end else begin
			case (rdIdx_r)
				`SSSF_IDX_STATUS: rdMux[7:0] = {statusUpper, flags};
				`SSSF_IDX_CNT_LO: rdMux[7:0] = count[7:0];
				`SSSF_IDX_CNT_HI: rdMux[1:0] = count[9:8];
				`SSSF_IDX_CFG: begin
					rdMux[`SSSF_CFG_THR_MSB:`SSSF_CFG_THR_LSB] = thr_r;
					rdMux[`SSSF_CFG_POL_MSB:`SSSF_CFG_POL_LSB] = pol_r;
				end
				`SSSF_IDX_IRQ_STAT: rdMux[3:0] = irqStat_r;
				`SSSF_IDX_IRQ_EN: rdMux[3:0] = irqEn_r;
				`SSSF_IDX_IRQ_CLR: rdMux = 32'h0000_0000; // write-only, reads zero
				default: rdOk = 1'b0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// write channel: address and data taken in either order
	always_comb begin
		doWrite = awHeld_r && wHeld_r && !s_axi_bvalid;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			awHeld_r <= 1'b0;
			wHeld_r <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			awIdx_r <= 7'h00;
			wData_r <= 32'h0000_0000;
			wStrb_r <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld_r <= 1'b1;
				s_axi_awready <= 1'b0;
				awIdx_r <= s_axi_awaddr[8:2];
			end else if (doWrite) begin
				awHeld_r <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld_r <= 1'b1;
				s_axi_wready <= 1'b0;
				wData_r <= s_axi_wdata;
				wStrb_r <= s_axi_wstrb;
			end else if (doWrite) begin
				wHeld_r <= 1'b0;
			end
			// reopen both channels once the response is taken
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// write response; status and count words accept and ignore writes
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `SSSF_RESP_OKAY;
		end else if (doWrite) begin
			s_axi_bvalid <= 1'b1;
			case (awIdx_r)
				`SSSF_IDX_CFG, `SSSF_IDX_IRQ_CLR, `SSSF_IDX_IRQ_EN,
				`SSSF_IDX_STATUS, `SSSF_IDX_CNT_LO, `SSSF_IDX_CNT_HI,
				`SSSF_IDX_IRQ_STAT: s_axi_bresp <= `SSSF_RESP_OKAY;
				default: s_axi_bresp <= `SSSF_RESP_SLVERR;
			endcase
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	// configuration register, byte lanes honoured
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			thr_r <= `SSSF_RST_THR;
			pol_r <= `SSSF_RST_POL;
		end else if (doWrite && (awIdx_r == `SSSF_IDX_CFG)) begin
			if (wStrb_r[0]) begin
				thr_r[7:0] <= wData_r[7:0];
			end
			if (wStrb_r[1]) begin
				thr_r[9:8] <= wData_r[`SSSF_CFG_THR_MSB:8];
			end
			if (wStrb_r[2]) begin
				pol_r <= wData_r[`SSSF_CFG_POL_MSB:`SSSF_CFG_POL_LSB];
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// interrupt enable register
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			irqEn_r <= `SSSF_RST_IRQ;
		end else if (doWrite && (awIdx_r == `SSSF_IDX_IRQ_EN) && wStrb_r[0]) begin
			irqEn_r <= wData_r[3:0];
		end
	end

	////////////////////////////////////////////////////////////////
	// sticky event bits: rising flags set, clear writes drop, set wins
	always_comb begin
		irqClr = 4'h0;
		if (doWrite && (awIdx_r == `SSSF_IDX_IRQ_CLR) && wStrb_r[0]) begin
			irqClr = wData_r[3:0];
		end
		events = flags & ~flagsPrev_r;
		irqStat_nxt = (irqStat_r & ~irqClr) | events;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			flagsPrev_r <= 4'h0;
			irqStat_r <= `SSSF_RST_IRQ;
			irq <= 1'b0;
		end else begin
			flagsPrev_r <= flags;
			irqStat_r <= irqStat_nxt;
			irq <= |(irqStat_nxt & irqEn_r);
		end
	end
endmodule
`default_nettype wire

/* hdl/sssf_cfg.svh */
// Contract
// - status bit 3 flags FIFO overflow
// - after overflow, block writes until host pops
// - overflow only in keep-oldest policy
// - status bit 2 when count exceeds threshold
// - watermark rises on sample passing threshold value
// - status bit 1 while FIFO holds samples
// - bit 0 set on new sample, cleared by read
// - no data-ready set during data register read
// - flag low before read: set after read
// - flag high before read: clear, then set again
// - report stored sample count 0 to 512
// - count split over low and high registers
// - high count register bits [1:0], rest zero
`ifndef SSSF_CFG_SVH
`define SSSF_CFG_SVH

// register word indices; byte address is index times four
`define SSSF_IDX_STATUS 7'h0B
`define SSSF_IDX_CNT_LO 7'h0C
`define SSSF_IDX_CNT_HI 7'h0D
`define SSSF_IDX_CFG 7'h40
`define SSSF_IDX_IRQ_STAT 7'h41
`define SSSF_IDX_IRQ_CLR 7'h42
`define SSSF_IDX_IRQ_EN 7'h43

// data register ranges whose reads interact with data ready
`define SSSF_IDX_DATA8_FIRST 7'h08
`define SSSF_IDX_DATA8_LAST 7'h0A
`define SSSF_IDX_DATA14_FIRST 7'h0E
`define SSSF_IDX_DATA14_LAST 7'h17
// upper-byte axis registers that do not clear data ready
`define SSSF_IDX_XHI 7'h0E
`define SSSF_IDX_YHI 7'h10
`define SSSF_IDX_ZHI 7'h12

// status bit positions
`define SSSF_BIT_DRDY 0
`define SSSF_BIT_FREADY 1
`define SSSF_BIT_LEVEL 2
`define SSSF_BIT_OVF 3

// configuration field layout
`define SSSF_CFG_THR_LSB 0
`define SSSF_CFG_THR_MSB 9
`define SSSF_CFG_POL_LSB 16
`define SSSF_CFG_POL_MSB 17

// reset values
`define SSSF_RST_THR 10'h000
`define SSSF_RST_POL 2'h0
`define SSSF_RST_IRQ 4'h0

// bus responses
`define SSSF_RESP_OKAY 2'h0
`define SSSF_RESP_SLVERR 2'h2

`endif

/* hdl/sssf_pkg.sv */
package sssf_pkg;
	// storage policy of the sample FIFO, in field encoding order
	typedef enum logic [1:0] {POL_BYPASS, POL_OLDEST, POL_STREAM, POL_TRIGGER} sssf_policy_e;
	// read channel sequencing
	typedef enum logic [1:0] {RD_IDLE, RD_FETCH, RD_RESP} sssf_rd_state_e;
endpackage

/* hdl/sssf_fill_counter.sv */
`timescale 1ns/1ps
`default_nettype none
module sssf_fill_counter
	import sssf_pkg::*;
#(
	parameter int COUNT_W = 10,
	parameter logic [9:0] DEPTH = 10'h200
) (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// configuration
	input wire sssf_policy_e policy,
	input wire logic [COUNT_W-1:0] threshold,
	// FIFO events
	input wire logic samplePush,
	input wire logic fifoPop,
	// results
	output logic [COUNT_W-1:0] count_r,
	output logic overflow_r,
	output logic levelReached_r,
	output logic nonEmpty_r,
	output logic writeEn_r,
	output logic dropOldest_r
);
	logic full; // no free location left
	logic popOk; // a pop that really removes a sample
	logic space; // room for the incoming sample this cycle
	logic accept; // sample is written
	logic drop; // oldest sample discarded to make room
	logic ovfSet; // overflow event this cycle
	logic [COUNT_W-1:0] count_nxt;

	////////////////////////////////////////////////////////////////
	// write admission per policy
	always_comb begin
		full = (count_r == DEPTH);
		popOk = fifoPop && (count_r != '0);
		space = !full || popOk;
		accept = 1'b0;
		drop = 1'b0;
		ovfSet = 1'b0;
		case (policy)
			POL_OLDEST: begin
				// once overrun, nothing enters until a pop frees space
				accept = samplePush && space && (!overflow_r || popOk);
				ovfSet = samplePush && !space;
			end
			POL_STREAM, POL_TRIGGER: begin
				// newest wins: oldest is thrown away when full
				accept = samplePush;
				drop = samplePush && full && !popOk;
			end
			default: begin
				// bypass keeps nothing
				accept = 1'b0;
			end
		endcase
		count_nxt = count_r + COUNT_W'(accept) - COUNT_W'(popOk) - COUNT_W'(drop);
		if (policy == POL_BYPASS) begin
			count_nxt = '0;
		end
	end

	////////////////////////////////////////////////////////////////
	// occupancy count
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			count_r <= '0;
		end else begin
			count_r <= count_nxt;
		end
	end

	////////////////////////////////////////////////////////////////
	// overflow flag, only meaningful in keep-oldest policy
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			overflow_r <= 1'b0;
		end else if (policy != POL_OLDEST) begin
			overflow_r <= 1'b0;
		end else if (ovfSet) begin
			overflow_r <= 1'b1;
		end else if (popOk) begin
			overflow_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	// level flags follow the new count so they agree with it
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			levelReached_r <= 1'b0;
			nonEmpty_r <= 1'b0;
		end else begin
			levelReached_r <= (count_nxt > threshold);
			nonEmpty_r <= (count_nxt != '0);
		end
	end

	////////////////////////////////////////////////////////////////
	// strobes to the FIFO storage
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			writeEn_r <= 1'b0;
			dropOldest_r <= 1'b0;
		end else begin
			writeEn_r <= accept;
			dropOldest_r <= drop;
		end
	end
endmodule
`default_nettype wire

/* hdl/sssf_data_ready.sv */
`timescale 1ns/1ps
`default_nettype none
module sssf_data_ready (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// events
	input wire logic newSample,
	input wire logic readStart,
	input wire logic readEnd,
	input wire logic readClears,
	// flag
	output logic dataReady_r
);
	logic inRead_r; // a data register read is under way
	logic wasSet_r; // flag value when the read began
	logic pending_r; // sample arrived while the read ran

	////////////////////////////////////////////////////////////////
	// read window tracking
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			inRead_r <= 1'b0;
			wasSet_r <= 1'b0;
			pending_r <= 1'b0;
		end else if (readStart) begin
			inRead_r <= 1'b1;
			wasSet_r <= dataReady_r;
			pending_r <= newSample; // a sample on the start edge counts as during the read
		end else if (readEnd) begin
			inRead_r <= 1'b0;
			pending_r <= 1'b0;
		end else if (inRead_r && newSample) begin
			pending_r <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////
	// flag: held low during a read, settled at its end
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			dataReady_r <= 1'b0;
		end else if (readStart) begin
			dataReady_r <= 1'b0;
		end else if (readEnd) begin
			// an upper-byte read leaves the sample unread, so the flag comes back
			dataReady_r <= pending_r || newSample || (wasSet_r && !readClears);
		end else if (inRead_r) begin
			dataReady_r <= 1'b0;
		end else if (newSample) begin
			dataReady_r <= 1'b1;
		end
	end
endmodule
`default_nettype wire

/* sim/sssf_top_chk.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sssf_cfg.svh"
module sssf_top_chk #(
	parameter int ADDR_W = 9
) (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// read channel
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// write response
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// sample path
	input wire logic samplePush,
	input wire logic fifoWriteEn,
	input wire logic dataRdStrobe,
	input wire logic [6:0] dataRdIndex,
	input wire logic irq
);
	// word index of a read request and its class
	logic [6:0] arIdx;
	logic arTake, inData, mapped;
	assign arIdx = s_axi_araddr[8:2];
	assign arTake = s_axi_arvalid && s_axi_arready;
	assign inData = (arIdx >= `SSSF_IDX_DATA8_FIRST && arIdx <= `SSSF_IDX_DATA8_LAST)
		|| (arIdx >= `SSSF_IDX_DATA14_FIRST && arIdx <= `SSSF_IDX_DATA14_LAST);
	// the map has no holes inside these two runs
	assign mapped = inData || (arIdx >= `SSSF_IDX_STATUS && arIdx <= `SSSF_IDX_CNT_HI)
		|| (arIdx >= `SSSF_IDX_CFG && arIdx <= `SSSF_IDX_IRQ_EN);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	////////////////////////////////////////////////////////////////////////////
	chk_push_only: assert property (!samplePush |=> !fifoWriteEn)
		else $error("FIFO write without a push");
	chk_strobe_idx: assert property (arTake && inData |=> dataRdStrobe && dataRdIndex == $past(arIdx))
		else $error("data lookup missing or wrong index");
	chk_strobe_none: assert property (arTake && !inData |=> !dataRdStrobe)
		else $error("data lookup on a non-data read");
	chk_strobe_once: assert property (dataRdStrobe |=> !dataRdStrobe)
		else $error("data lookup longer than one cycle");
	chk_rd_answer: assert property (arTake |-> !s_axi_rvalid ##2 s_axi_rvalid)
		else $error("read answer not two cycles after take");
	chk_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before handshake");
	chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before handshake");
	chk_unmapped_err: assert property (arTake && !mapped |-> ##2 s_axi_rresp == `SSSF_RESP_SLVERR
		&& s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
	chk_cnthi_zero: assert property (arTake && arIdx == `SSSF_IDX_CNT_HI |-> ##2
		s_axi_rdata[31:2] == 30'h0 && s_axi_rdata[1:0] != 2'h3)
		else $error("count high word out of range");
	// main scenarios reached
	cover property (arTake && inData);
	cover property (fifoWriteEn);
	cover property ($rose(irq));
	cover property (arTake && !mapped);
endmodule
bind sssf_top sssf_top_chk #(.ADDR_W(ADDR_W)) sssf_top_chk_inst (.clk(clk), .resetn(resetn),
	.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .samplePush(samplePush), .fifoWriteEn(fifoWriteEn),
	.dataRdStrobe(dataRdStrobe), .dataRdIndex(dataRdIndex), .irq(irq));
`default_nettype wire

/* sim/sssf_sample_src.sv */
`timescale 1ns/1ps
`default_nettype none
module sssf_sample_src (
	// clock
	input wire logic clk,
	// lookup from the block
	input wire logic dataRdStrobe,
	input wire logic [6:0] dataRdIndex,
	output logic [7:0] dataRdValue
);
	// filler flips every cycle so a late sample of the bus never passes as data
	logic [7:0] junk_r = 8'h5A;
	always_ff @(posedge clk) begin
		junk_r <= ~junk_r;
	end
	// byte valid only in the lookup cycle: top bit set, index below
	assign dataRdValue = dataRdStrobe ? {1'b1, dataRdIndex} : junk_r;
endmodule
`default_nettype wire

/* sim/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	// clock, reset and bus
	logic clk = 1'b0;
	logic resetn;
	logic [8:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb, statusUpper;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr, wr;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	// sample path
	logic newSample, samplePush, fifoPop, dataRdStrobe, fifoWriteEn, fifoDropOldest, irq;
	logic [6:0] dataRdIndex;
	logic [7:0] dataRdValue;
	int n_fail = 0;
	int n_tests = 0;
	int nWr = 0; // admitted FIFO writes seen on the storage strobe
	int nDrop = 0; // oldest-sample discards seen on the storage strobe
	localparam logic [8:0] ST = 9'h02C, LO = 9'h030, HI = 9'h034, CFG = 9'h100;
	always #5 clk = ~clk;
	sssf_top sssf_top_inst (.clk(clk), .resetn(resetn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .newSample(newSample), .samplePush(samplePush),
		.fifoPop(fifoPop), .statusUpper(statusUpper), .dataRdStrobe(dataRdStrobe),
		.dataRdIndex(dataRdIndex), .dataRdValue(dataRdValue), .fifoWriteEn(fifoWriteEn),
		.fifoDropOldest(fifoDropOldest), .irq(irq));
	sssf_sample_src sssf_sample_src_inst (.clk(clk), .dataRdStrobe(dataRdStrobe),
		.dataRdIndex(dataRdIndex), .dataRdValue(dataRdValue));
	// count storage strobes so every admitted or dropped sample is accounted for
	always @(posedge clk) begin
		if (resetn && fifoWriteEn) begin
			nWr <= nWr + 1;
		end
		if (resetn && fifoDropOldest) begin
			nDrop <= nDrop + 1;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	task automatic final_report;
		$display("comparisons=%0d mismatches=%0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// a wait that used its whole bound ends the run
	task automatic tmo(input int i);
		if (i >= 50) begin
			n_fail++;
			final_report;
		end
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// write: address and data offered together, each dropped when taken
	task automatic axw(input logic [8:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		wr = s_axi_bresp;
		s_axi_bready <= 1'b0;
		tmo(i);
	endtask
	task automatic axr(input logic [8:0] a);
		int i;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge clk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		rd = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'b0;
		tmo(i);
	endtask
	task automatic rc(input logic [8:0] a, input logic [31:0] e);
		axr(a);
		chk(rd, e);
	endtask
	// k drives {newSample, fifoPop, samplePush} for n cycles
	task automatic evt(input int n, input logic [2:0] k);
		repeat (n) begin
			@(posedge clk);
			{newSample, fifoPop, samplePush} <= k;
		end
		@(posedge clk);
		{newSample, fifoPop, samplePush} <= 3'h0;
	endtask
	// data read with a new sample landing inside the read
	task automatic rdNs(input logic [8:0] a);
		fork
			axr(a);
			begin
				repeat (2) @(posedge clk);
				newSample <= 1'b1;
				@(posedge clk);
				newSample <= 1'b0;
			end
		join
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		resetn = 1'b0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{newSample, fifoPop, samplePush} = 3'h0;
		s_axi_wstrb = 4'hF;
		statusUpper = 4'h5;
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		rc(ST, 32'h50);
		rc(LO, 32'h0);
		rc(HI, 32'h0);
		// keep-oldest, threshold 3, interrupt on non-empty
		axw(9'h10C, 32'h2);
		axw(CFG, 32'h0001_0003);
		evt(3, 3'h1);
		rc(ST, 32'h52);
		rc(9'h104, 32'h2);
		chk({31'h0, irq}, 32'h1);
		evt(1, 3'h1);
		rc(ST, 32'h56);
		rc(LO, 32'h4);
		axw(ST, 32'hFF);
		chk({30'h0, wr}, 32'h0);
		rc(ST, 32'h56);
		// masked but still pending, then cleared
		axw(9'h10C, 32'h0);
		rc(9'h104, 32'h6);
		chk({31'h0, irq}, 32'h0);
		axw(9'h108, 32'hF);
		rc(9'h104, 32'h0);
		// fill to 512, then overrun
		evt(508, 3'h1);
		rc(HI, 32'h2);
		rc(LO, 32'h0);
		evt(1, 3'h1);
		rc(ST, 32'h5E);
		evt(1, 3'h1);
		rc(HI, 32'h2);
		evt(1, 3'h2);
		rc(ST, 32'h56);
		rc(LO, 32'hFF);
		evt(511, 3'h2);
		rc(ST, 32'h50);
		// stream and trigger drop the oldest without an overrun flag
		for (int p = 2; p < 4; p++) begin
			axw(CFG, {14'h0, p[1:0], 16'h0003});
			evt(513, 3'h1);
			rc(ST, 32'h56);
		end
		axw(CFG, 32'h0);
		rc(ST, 32'h50);
		// keep-oldest admitted 512, each streaming pass 513; only full pushes drop
		chk(32'(nWr), 32'd1538);
		chk(32'(nDrop), 32'd514);
		// new-sample flag around data reads
		evt(1, 3'h4);
		rc(ST, 32'h51);
		rc(ST, 32'h51);
		rc(9'h020, 32'h88);
		rc(ST, 32'h50);
		rdNs(9'h024);
		rc(ST, 32'h51);
		rdNs(9'h028);
		rc(ST, 32'h51);
		rc(9'h038, 32'h8E);
		rc(ST, 32'h51);
		rc(9'h03C, 32'h8F);
		rc(ST, 32'h50);
		// unmapped word refused both ways
		axw(9'h1F0, 32'h1);
		chk({30'h0, wr}, 32'h2);
		axr(9'h1F0);
		chk({30'h0, rr}, 32'h2);
		chk(rd, 32'h0);
		final_report;
	end
endmodule
`default_nettype wire
